// file: common/selftest_status_map.vh
// register offsets, field positions and reset values of the status group
`ifndef SELFTEST_STATUS_MAP_VH
`define SELFTEST_STATUS_MAP_VH
`define ADDR_W               10
`define OFS_RESULT_MISC      10'h225
`define OFS_COMPLETION       10'h226
`define OFS_CONV_ORDER       10'h230
`define OFS_LIN_ORDER        10'h231
`define RST_REG8             8'h00
`define BIT_AUTO_ZERO        5
`define BIT_HOUSEKEEPING     4
`define BIT_FUSE_SHADOW      3
`define BIT_SAFETY_STOP      2
`define BIT_RESET_PIN        1
`define BIT_TRACKER_TEMP     0
`define BIT_LOGIC_PASS       7
`define BIT_LOGIC_DONE       6
`define BIT_LOGIC_CLEAR      4
`define BIT_ANALOG_PASS      3
`define BIT_ANALOG_DONE      2
`define BIT_ANALOG_CLEAR     0
`define ORDER_HI_LSB         4
`define ORDER_LO_LSB         0
`define ORDER_W              3
`define ORDER_OFF            3'h0
`define ORDER_FIRST          3'h1
`define ORDER_LAST           3'h5
`endif

// file: logic/selftest_result_pair.v
// done and pass flag pair of one self-test engine
`timescale 1ns/100ps
module selftest_result_pair (
  input  wire clock,
  input  wire rst_b,
  input  wire runFinished,
  input  wire runPassed,
  input  wire clearStrobe,
  output reg  done_reg,
  output reg  pass_reg
);
  // a finishing run wins over a clear in the same cycle so no result is lost
  always @(posedge clock) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else if (runFinished) begin
      done_reg <= 1'b1;
      pass_reg <= runPassed;
    end else if (clearStrobe) begin
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
    end
  end
endmodule

// file: logic/startup_order_slot.v
// power-up order slot of one rail, taken from the sequencer
`timescale 1ns/100ps
`include "selftest_status_map.vh"
module startup_order_slot (
  input  wire       clock,
  input  wire       rst_b,
  input  wire       railOn,
  input  wire       slotStart,
  input  wire [2:0] currentSlot,
  output reg  [2:0] order_reg
);
  // rails started in one slot all latch the same slot number
  always @(posedge clock) begin
    if (!rst_b)
      order_reg <= `ORDER_OFF;
    else if (!railOn)
      order_reg <= `ORDER_OFF;
    // latch only while still unstarted: later slots must not renumber a rail
    else if (slotStart && order_reg == `ORDER_OFF &&
             currentSlot >= `ORDER_FIRST && currentSlot <= `ORDER_LAST)
      order_reg <= currentSlot;
  end
endmodule

// file: logic/selftest_startup_status.v
// self-test result and startup order status register group
// Function
// - bits 5,4: auto-zero and housekeeping check
// - bits 2,1: safety-stop and reset pin checks
// - bit 0: tracker temperature sensor check
// - bit 3 set only on shadow-fuse match
// - option shadow write returns bit 3 to 0
// - bit 7: logic self-test pass
// - bit 6: logic self-test complete
// - write 1 to bit 4 clears logic flags
// - logic flags update on every run
// - bits 3,2: analog pass and complete
// - write 1 to bit 0 clears analog flags
// - converter orders at bits 6:4 and 2:0
// - linear regulator orders at 6:4, 2:0
// - same slot gives same order value
// - primary converter expected at order 1
`timescale 1ns/100ps
`include "selftest_status_map.vh"
module selftest_startup_status (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [9:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata_reg,
  input  wire        autoZeroCheckOk,
  input  wire        housekeepingCheckOk,
  input  wire        safetyStopPinCheckOk,
  input  wire        resetPinCheckOk,
  input  wire        trackerTempCheckOk,
  input  wire        fuseLoadDone,
  input  wire        fuseMatch,
  input  wire        optionShadowWrite,
  input  wire        logicRunFinished,
  input  wire        logicRunPassed,
  input  wire        analogRunFinished,
  input  wire        analogRunPassed,
  input  wire [3:0]  railOn,
  input  wire        slotStart,
  input  wire [2:0]  currentSlot
);
  reg  [4:0] checkOk_reg;
  reg        fuseShadow_reg;
  wire       logicDone;
  wire       logicPass;
  wire       analogDone;
  wire       analogPass;
  wire [2:0] primaryConverterOrder;
  wire [2:0] secondConverterOrder;
  wire [2:0] linearRegOneOrder;
  wire [2:0] linearRegTwoOrder;
  wire       completionWrite;
  reg  [7:0] regRdata_next;

  assign completionWrite = regWrite && (regAddr == `OFS_COMPLETION);

  // check results are levels from the monitors on this clock
  always @(posedge clock) begin
    if (!rst_b)
      checkOk_reg <= 5'h00;
    else
      checkOk_reg <= {autoZeroCheckOk, housekeepingCheckOk,
                      safetyStopPinCheckOk, resetPinCheckOk,
                      trackerTempCheckOk};
  end

  // a shadow write always drops the flag, even on a load cycle,
  // since a modified shadow no longer reflects the fuse load
  always @(posedge clock) begin
    if (!rst_b)
      fuseShadow_reg <= 1'b0;
    else if (optionShadowWrite)
      fuseShadow_reg <= 1'b0;
    else if (fuseLoadDone)
      fuseShadow_reg <= fuseMatch;
  end

  selftest_result_pair logicPair (
    .clock       (clock),
    .rst_b       (rst_b),
    .runFinished (logicRunFinished),
    .runPassed   (logicRunPassed),
    .clearStrobe (completionWrite && regWdata[`BIT_LOGIC_CLEAR]),
    .done_reg    (logicDone),
    .pass_reg    (logicPass)
  );

  selftest_result_pair analogPair (
    .clock       (clock),
    .rst_b       (rst_b),
    .runFinished (analogRunFinished),
    .runPassed   (analogRunPassed),
    .clearStrobe (completionWrite && regWdata[`BIT_ANALOG_CLEAR]),
    .done_reg    (analogDone),
    .pass_reg    (analogPass)
  );

  // railOn[0] primary converter, [1] second, [2] lin one, [3] lin two;
  // the primary is started in slot one by the sequencer
  startup_order_slot primaryConverterSlot (
    .clock       (clock),
    .rst_b       (rst_b),
    .railOn      (railOn[0]),
    .slotStart   (slotStart),
    .currentSlot (currentSlot),
    .order_reg   (primaryConverterOrder)
  );

  startup_order_slot secondConverterSlot (
    .clock       (clock),
    .rst_b       (rst_b),
    .railOn      (railOn[1]),
    .slotStart   (slotStart),
    .currentSlot (currentSlot),
    .order_reg   (secondConverterOrder)
  );

  startup_order_slot linearRegOneSlot (
    .clock       (clock),
    .rst_b       (rst_b),
    .railOn      (railOn[2]),
    .slotStart   (slotStart),
    .currentSlot (currentSlot),
    .order_reg   (linearRegOneOrder)
  );

  startup_order_slot linearRegTwoSlot (
    .clock       (clock),
    .rst_b       (rst_b),
    .railOn      (railOn[3]),
    .slotStart   (slotStart),
    .currentSlot (currentSlot),
    .order_reg   (linearRegTwoOrder)
  );

  // read mux; unmapped and reserved positions read as zero
  always @* begin
    regRdata_next = `RST_REG8;
    case (regAddr)
      `OFS_RESULT_MISC: begin
        regRdata_next[`BIT_AUTO_ZERO]    = checkOk_reg[4];
        regRdata_next[`BIT_HOUSEKEEPING] = checkOk_reg[3];
        regRdata_next[`BIT_FUSE_SHADOW]  = fuseShadow_reg;
        regRdata_next[`BIT_SAFETY_STOP]  = checkOk_reg[2];
        regRdata_next[`BIT_RESET_PIN]    = checkOk_reg[1];
        regRdata_next[`BIT_TRACKER_TEMP] = checkOk_reg[0];
      end
      `OFS_COMPLETION: begin
        regRdata_next[`BIT_LOGIC_PASS]  = logicPass;
        regRdata_next[`BIT_LOGIC_DONE]  = logicDone;
        regRdata_next[`BIT_ANALOG_PASS] = analogPass;
        regRdata_next[`BIT_ANALOG_DONE] = analogDone;
        // clear bits stay zero: they are strobes only
        regRdata_next[`BIT_LOGIC_CLEAR]  = 1'b0;
        regRdata_next[`BIT_ANALOG_CLEAR] = 1'b0;
      end
      `OFS_CONV_ORDER: begin
        regRdata_next[`ORDER_HI_LSB +: `ORDER_W] = secondConverterOrder;
        regRdata_next[`ORDER_LO_LSB +: `ORDER_W] = primaryConverterOrder;
      end
      `OFS_LIN_ORDER: begin
        regRdata_next[`ORDER_HI_LSB +: `ORDER_W] = linearRegTwoOrder;
        regRdata_next[`ORDER_LO_LSB +: `ORDER_W] = linearRegOneOrder;
      end
      default: regRdata_next = `RST_REG8;
    endcase
  end

  // read data registered; held between reads
  always @(posedge clock) begin
    if (!rst_b)
      regRdata_reg <= `RST_REG8;
    else if (regRead)
      regRdata_reg <= regRdata_next;
  end
endmodule

// file: dv/status_asserts.sv
// concurrent checks on the status group register port
`timescale 1ns/100ps
module status_asserts (
  input logic       clock,
  input logic       rst_b,
  input logic [9:0] regAddr,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regWdata,
  input logic [7:0] regRdata_reg,
  input logic       logicRunFinished,
  input logic       logicRunPassed,
  input logic       analogRunFinished,
  input logic       optionShadowWrite
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire rdMisc = regRead && regAddr == 10'h225;
  wire rdDone = regRead && regAddr == 10'h226;
  wire rdOrd = regRead && (regAddr == 10'h230 || regAddr == 10'h231);
  wire wrDone = regWrite && regAddr == 10'h226;
  misc_rsv_a: assert property (rdMisc |=>
    regRdata_reg[7:6] == 2'h0) else $error("misc reserved set");
  done_rsv_a: assert property (rdDone |=>
    (regRdata_reg & 8'h33) == 8'h00) else $error("done reserved set");
  ord_rsv_a: assert property (rdOrd |=>
    (regRdata_reg & 8'h88) == 8'h00) else $error("order reserved set");
  unmapped_a: assert property (regRead && !(rdMisc|rdDone|rdOrd) |=>
    regRdata_reg == 8'h00) else $error("unmapped read not zero");
  logic_clr_a: assert property (wrDone && regWdata[4] && !logicRunFinished
    ##1 rdDone |=> regRdata_reg[7:6] == 2'h0) else $error("logic clear lost");
  ana_clr_a: assert property (wrDone && regWdata[0] && !analogRunFinished
    ##1 rdDone |=> regRdata_reg[3:2] == 2'h0) else $error("analog clear lost");
  logic_run_a: assert property (logicRunFinished ##1 rdDone |=>
    regRdata_reg[7:6] == {$past(logicRunPassed, 2), 1'h1})
    else $error("logic run flags wrong");
  shadow_wr_a: assert property (optionShadowWrite ##1 rdMisc |=>
    !regRdata_reg[3]) else $error("fuse bit kept after shadow write");
endmodule
bind selftest_startup_status status_asserts status_asserts_i (.clock, .rst_b,
  .regAddr, .regWrite, .regRead, .regWdata, .regRdata_reg, .logicRunFinished,
  .logicRunPassed, .analogRunFinished, .optionShadowWrite);

// file: dv/selftest_startup_status_tb.sv
// self-checking bench of the status register group
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin nMismatch++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module selftest_startup_status_tb;
  reg        clock, rst_b, regWrite, regRead, fuseMatch, lPass, aPass;
  reg        pend = 1'h0;
  reg  [9:0] regAddr;
  reg  [9:0] adr[5] = '{10'h225, 10'h226, 10'h230, 10'h231, 10'h3FF};
  reg  [7:0] regWdata, rnd, got, expQ[$];
  reg  [4:0] ok, pv;
  reg  [3:0] railOn;
  reg  [2:0] currentSlot;
  wire [7:0] regRdata_reg;
  int        checked = 0, nMismatch = 0, cycles = 0;
  selftest_startup_status selftest_startup_status_i (.clock, .rst_b, .regAddr,
    .regWrite, .regRead, .regWdata, .regRdata_reg, .autoZeroCheckOk(ok[4]),
    .housekeepingCheckOk(ok[3]), .safetyStopPinCheckOk(ok[2]),
    .resetPinCheckOk(ok[1]), .trackerTempCheckOk(ok[0]), .fuseLoadDone(pv[0]),
    .fuseMatch, .optionShadowWrite(pv[1]), .logicRunFinished(pv[2]),
    .logicRunPassed(lPass), .analogRunFinished(pv[3]), .analogRunPassed(aPass),
    .railOn, .slotStart(pv[4]), .currentSlot);
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // every strobe set once per step, so back-to-back requests need no gap
  task op(input [9:0] a, input [7:0] d, input r, w, input [4:0] p);
    regAddr = a;
    regWdata = d;
    regRead = r;
    regWrite = w;
    pv = p;
    @(posedge clock);
    #1;
  endtask
  task rd(input [9:0] a, input [7:0] e);
    expQ.push_back(e);
    op(a, 8'h00, 1'h1, 1'h0, 5'h00);
  endtask
  task wr(input [9:0] a, input [7:0] d);
    op(a, d, 1'h0, 1'h1, 5'h00);
  endtask
  task pulse(input [4:0] p);
    op(10'h000, 8'h00, 1'h0, 1'h0, p);
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      conclude;
    end
    pend <= regRead;
  end
  // compare mid-cycle, clear of the edge that launches the read data
  always @(negedge clock) begin
    if (pend) begin
      got = expQ.pop_front();
      `CHK(regRdata_reg, got)
    end
  end
  initial begin
    clock = 1'h0;
    rst_b = 1'h0;
    rnd = 8'h0C;
    {ok, fuseMatch, lPass, aPass, railOn, currentSlot} = '0;
    repeat (3) pulse(5'h00);
    rst_b = 1'h1;
    foreach (adr[i]) rd(adr[i], 8'h00);
    repeat (4) begin
      rnd = lfsr(rnd);
      ok = rnd[4:0];
      fuseMatch = rnd[5];
      pulse(5'h01);
      wr(10'h225, 8'hFF);
      rd(10'h225, {2'h0, rnd[4:3], rnd[5], rnd[2:0]});
    end
    fuseMatch = 1'h1;
    pulse(5'h01);
    rd(10'h225, {2'h0, rnd[4:3], 1'h1, rnd[2:0]});
    pulse(5'h03);
    rd(10'h225, {2'h0, rnd[4:3], 1'h0, rnd[2:0]});
    lPass = 1'h1;
    pulse(5'h0C);
    wr(10'h226, 8'hEE);
    rd(10'h226, 8'hC4);
    wr(10'h226, 8'h01);
    rd(10'h226, 8'hC0);
    wr(10'h226, 8'h10);
    rd(10'h226, 8'h00);
    lPass = 1'h0;
    aPass = 1'h1;
    pulse(5'h0C);
    rd(10'h226, 8'h4C);
    railOn = 4'h1;
    currentSlot = 3'h1;
    pulse(5'h10);
    railOn = 4'h7;
    currentSlot = 3'h2;
    pulse(5'h10);
    railOn = 4'hF;
    currentSlot = 3'h5;
    pulse(5'h10);
    rd(10'h230, 8'h21);
    rd(10'h231, 8'h52);
    railOn = 4'hD;
    pulse(5'h00);
    rd(10'h230, 8'h01);
    pulse(5'h00);
    pulse(5'h00);
    if (expQ.size() != 0) nMismatch++;
    conclude;
  end
endmodule
